// ==== shared/spc_pkg.sv ====
// SPI port control package: register map, field positions, types
package spc_pkg;
  localparam int CLK_NS = 25;
  localparam int STALL_NS = 400;
  localparam logic [7:0] STALL_CYC = 8'((STALL_NS + CLK_NS - 1) / CLK_NS);
  // register byte addresses
  localparam logic [4:0] OFF_STAT = 5'h00;
  localparam logic [4:0] OFF_RX = 5'h04;
  localparam logic [4:0] OFF_TX = 5'h08;
  localparam logic [4:0] OFF_DIV = 5'h0c;
  localparam logic [4:0] OFF_CTL = 5'h10;
  localparam logic [4:0] OFF_IST = 5'h14;
  localparam logic [4:0] OFF_IMSK = 5'h18;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'h1fef;
  localparam logic [7:0] DIV_RST = 8'h1b;
  // control field positions
  localparam int B_EN = 0;
  localparam int B_MST = 1;
  localparam int B_PHA = 2;
  localparam int B_POL = 3;
  localparam int B_LSB = 5;
  localparam int B_TMOD = 6;
  localparam int B_UDM = 7;
  localparam int B_OVW = 8;
  localparam int B_SSE = 9;
  localparam int B_SOE = 10;
  localparam int B_LB = 11;
  localparam int B_CONT = 12;
  // interrupt status positions
  localparam int I_TXE = 0;
  localparam int I_RXF = 1;
  localparam int I_OVF = 2;
  localparam int I_UDF = 3;
  localparam logic [3:0] LAST_HALF = 4'hf;
  localparam logic [3:0] LAST_BIT = 4'h7;
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_STALL} spc_fsm_t;
  typedef struct packed {logic sclk; logic mosi; logic miso; logic ss_n;} spc_pin_in_t;
  typedef struct packed {
    logic sclk_o; logic sclk_oe; logic mosi_o; logic mosi_oe;
    logic miso_o; logic miso_oe; logic ss_n_o; logic ss_oe;
  } spc_pin_out_t;
  typedef struct packed {logic [4:0] addr; logic [15:0] wdata; logic wr; logic rd;} spc_bus_t;
  typedef struct packed {
    logic [15:0] ctl; logic [7:0] div; logic [7:0] tx; logic txv; logic [7:0] last;
    logic [7:0] rx; logic rxf; logic ovf; logic udf; logic [3:0] ist; logic [3:0] imsk;
    spc_fsm_t fsm; logic [7:0] sh; logic [7:0] rsh; logic [3:0] bitn; logic [3:0] half;
    logic [7:0] hc; logic [7:0] cnt; logic cs; logic go; logic [15:0] rdata;
    spc_pin_in_t s1; spc_pin_in_t s2; spc_pin_in_t s3;
  } spc_state_t;
  localparam spc_state_t ST_RST = '{ctl: CTL_RST, div: DIV_RST, fsm: ST_IDLE, default: '0};
endpackage : spc_pkg

// ==== hw/spc_port.sv ====
// SPI port: control register, master/slave shifter, status and interrupt
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module spc_port
(
  input wire logic clk,
  input wire logic rst_n,
  input wire spc_pkg::spc_bus_t bus_i,
  output logic [15:0] rdata,
  output logic irq,
  input wire spc_pkg::spc_pin_in_t pin_i,
  output spc_pkg::spc_pin_out_t pin_o
);
  spc_pkg::spc_state_t q;
  spc_pkg::spc_state_t d;
  logic en;
  logic mst;
  logic lsb;
  logic outbit;
  logic sin;
  logic rd_rx;
  logic start;
  logic samp;
  logic shft;
  logic done;
  logic lead;
  logic trail;
  logic [7:0] nrsh;
  logic [7:0] nb;
  logic [3:0] ev;

  // decoded control fields and serial data paths
  assign en = q.ctl[spc_pkg::B_EN];
  assign mst = q.ctl[spc_pkg::B_MST];
  assign lsb = q.ctl[spc_pkg::B_LSB];
  assign outbit = lsb ? q.sh[0] : q.sh[7];
  assign rd_rx = bus_i.rd && bus_i.addr == spc_pkg::OFF_RX;
  // synced pin levels only; first stage never read here
  assign sin = q.ctl[spc_pkg::B_LB] ? outbit : (mst ? q.s2.miso : q.s2.mosi);
  assign lead = (q.s2.sclk != q.ctl[spc_pkg::B_POL]) && (q.s3.sclk == q.ctl[spc_pkg::B_POL]);
  assign trail = (q.s2.sclk == q.ctl[spc_pkg::B_POL]) && (q.s3.sclk != q.ctl[spc_pkg::B_POL]);
  assign nrsh = lsb ? {sin, q.rsh[7:1]} : {q.rsh[6:0], sin};
  assign nb = q.txv ? q.tx : (q.ctl[spc_pkg::B_UDM] ? q.last : 8'h00);

  // transfer sequencing: start, sample, shift and done strobes
  always_comb
  begin
    start = 1'b0;
    samp = 1'b0;
    shft = 1'b0;
    done = 1'b0;
    if (en && q.fsm == spc_pkg::ST_IDLE)
    begin
      if (mst)
        start = q.ctl[spc_pkg::B_TMOD] ? q.txv : q.go;
      else
        start = q.s3.ss_n && !q.s2.ss_n;
    end
    if (en && q.fsm == spc_pkg::ST_XFER)
    begin
      if (mst)
      begin
        // mid-cell sample, cell-boundary shift: opposite clock edges
        if (q.hc == 8'h00)
        begin
          samp = !q.half[0];
          shft = q.half[0] && q.half != spc_pkg::LAST_HALF;
          done = q.half == spc_pkg::LAST_HALF;
        end
      end
      else if (!q.s2.ss_n)
      begin
        // slave edges chosen by phase
        samp = q.ctl[spc_pkg::B_PHA] ? trail : lead;
        shft = (q.ctl[spc_pkg::B_PHA] ? lead : trail) && q.bitn != 4'h0;
        done = samp && q.bitn == spc_pkg::LAST_BIT;
      end
    end
  end

  // next-state computation
  always_comb
  begin
    d = q;
    ev = 4'h0;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rdata = 16'h0000;
    // register reads, data one cycle later
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        spc_pkg::OFF_STAT:
          d.rdata = {10'h000, q.ovf, q.rxf | q.ovf, q.rxf, q.udf, !q.txv | q.udf, q.txv};
        spc_pkg::OFF_RX: d.rdata = {8'h00, q.rx};
        spc_pkg::OFF_DIV: d.rdata = {8'h00, q.div};
        spc_pkg::OFF_CTL: d.rdata = q.ctl;
        spc_pkg::OFF_IST: d.rdata = {12'h000, q.ist};
        spc_pkg::OFF_IMSK: d.rdata = {12'h000, q.imsk};
        default: d.rdata = 16'h0000;
      endcase
    end
    // receive read clears full and overflow; may trigger a transfer
    if (rd_rx)
    begin
      d.rxf = 1'b0;
      d.ovf = 1'b0;
      if (en && mst && !q.ctl[spc_pkg::B_TMOD])
        d.go = 1'b1;
    end
    // register writes
    if (bus_i.wr)
    begin
      if (bus_i.addr == spc_pkg::OFF_CTL)
        d.ctl = bus_i.wdata & spc_pkg::CTL_WMASK;
      if (bus_i.addr == spc_pkg::OFF_DIV)
        d.div = bus_i.wdata[7:0];
      if (bus_i.addr == spc_pkg::OFF_IST)
        d.ist = q.ist & ~bus_i.wdata[3:0];
      if (bus_i.addr == spc_pkg::OFF_IMSK)
        d.imsk = bus_i.wdata[3:0];
    end
    // load a byte at frame start
    if (start)
    begin
      d.fsm = spc_pkg::ST_XFER;
      d.sh = nb;
      d.last = nb;
      d.rsh = 8'h00;
      d.bitn = 4'h0;
      d.half = 4'h0;
      d.hc = q.div;
      d.go = 1'b0;
      d.cs = mst;
      d.txv = 1'b0;
      if (!q.txv)
      begin
        d.udf = 1'b1;
        ev[spc_pkg::I_UDF] = 1'b1;
      end
      else
        ev[spc_pkg::I_TXE] = q.ctl[spc_pkg::B_TMOD] || !mst;
    end
    // master clock divider: half cell is div+1 clocks
    if (en && mst && q.fsm == spc_pkg::ST_XFER)
    begin
      if (q.hc == 8'h00)
      begin
        d.hc = q.div;
        d.half = q.half + 4'h1;
      end
      else
        d.hc = q.hc - 8'h01;
    end
    if (samp)
    begin
      d.rsh = nrsh;
      d.bitn = q.bitn + 4'h1;
    end
    if (shft)
      d.sh = lsb ? {1'b0, q.sh[7:1]} : {q.sh[6:0], 1'b0};
    // byte complete: deliver to receive holding register unless it is full and overwrite is off
    if (done)
    begin
      if (!(q.rxf && !rd_rx) || q.ctl[spc_pkg::B_OVW])
        d.rx = mst ? q.rsh : nrsh;
      if (q.rxf && !rd_rx)
      begin
        d.ovf = 1'b1;
        ev[spc_pkg::I_OVF] = 1'b1;
      end
      d.rxf = 1'b1;
      ev[spc_pkg::I_RXF] = !q.ctl[spc_pkg::B_TMOD] || !mst;
      d.fsm = spc_pkg::ST_IDLE;
      d.cs = 1'b0;
      if (mst && q.txv && q.ctl[spc_pkg::B_CONT])
      begin
        // next byte back to back, select kept low
        d.fsm = spc_pkg::ST_XFER;
        d.cs = 1'b1;
        d.sh = q.tx;
        d.last = q.tx;
        d.txv = 1'b0;
        d.rsh = 8'h00;
        d.bitn = 4'h0;
        d.half = 4'h0;
        d.hc = q.div;
        ev[spc_pkg::I_TXE] = q.ctl[spc_pkg::B_TMOD];
      end
      else if (mst && q.txv && q.ctl[spc_pkg::B_TMOD])
      begin
        d.fsm = spc_pkg::ST_STALL;
        d.cnt = spc_pkg::STALL_CYC;
      end
    end
    // slave frame aborted by select release
    if (!mst && q.fsm == spc_pkg::ST_XFER && q.s2.ss_n)
      d.fsm = spc_pkg::ST_IDLE;
    if (q.fsm == spc_pkg::ST_STALL)
    begin
      d.cnt = q.cnt - 8'h01;
      if (q.cnt == 8'h01)
        d.fsm = spc_pkg::ST_IDLE;
    end
    // transmit write after start so a same-cycle write is kept
    if (bus_i.wr && bus_i.addr == spc_pkg::OFF_TX)
    begin
      d.tx = bus_i.wdata[7:0];
      d.txv = 1'b1;
      d.udf = ev[spc_pkg::I_UDF]; // underflow set wins over the clear
    end
    // sticky events, set wins over clear
    d.ist = d.ist | ev;
    if (!en)
    begin
      d.fsm = spc_pkg::ST_IDLE;
      d.cs = 1'b0;
      d.go = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= spc_pkg::ST_RST;
    else
      q <= d;
  end

  // bus answer and interrupt
  assign rdata = q.rdata;
  assign irq = |(q.ist & q.imsk);

  // pin drivers
  always_comb
  begin
    pin_o.sclk_oe = en && mst;
    pin_o.sclk_o = q.ctl[spc_pkg::B_POL] ^ (q.fsm == spc_pkg::ST_XFER && mst
      && (q.ctl[spc_pkg::B_PHA] ? !q.half[0] : q.half[0]));
    pin_o.mosi_oe = en && mst;
    pin_o.mosi_o = mst && q.fsm == spc_pkg::ST_XFER && outbit;
    pin_o.miso_oe = en && !mst && q.ctl[spc_pkg::B_SOE] && !q.s2.ss_n;
    pin_o.miso_o = !mst && outbit;
    pin_o.ss_oe = en && mst && q.ctl[spc_pkg::B_SSE];
    pin_o.ss_n_o = !q.cs;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_OFF_IDLE: assert property (!en |=> q.fsm == spc_pkg::ST_IDLE && pin_o.ss_n_o)
    else $error("disabled port not idle");
  AST_CONT: assert property (done && mst && q.txv && q.ctl[spc_pkg::B_CONT]
    |=> q.fsm == spc_pkg::ST_XFER && !pin_o.ss_n_o)
    else $error("continuous transfer dropped select");
  AST_STALL: assert property (done && mst && q.txv && !q.ctl[spc_pkg::B_CONT]
    && q.ctl[spc_pkg::B_TMOD] |=> (q.fsm == spc_pkg::ST_STALL)[*8])
    else $error("no stall between single transfers");
  AST_MISO: assert property (pin_o.miso_oe |-> !mst && q.ctl[spc_pkg::B_SOE])
    else $error("slave output driven while disabled");
  AST_SSOE: assert property (!q.ctl[spc_pkg::B_SSE] |-> !pin_o.ss_oe)
    else $error("select driven while disabled");
  AST_DISCARD: assert property (done && q.rxf && !rd_rx && !q.ctl[spc_pkg::B_OVW]
    |=> q.rx == $past(q.rx) && q.ovf)
    else $error("full receive register overwritten");
  AST_UNDER: assert property (start && !q.txv && !q.ctl[spc_pkg::B_UDM]
    |=> q.sh == 8'h00 && q.udf)
    else $error("underflow did not send zeros");
  AST_IDLE_CLK: assert property (q.fsm != spc_pkg::ST_XFER
    |-> pin_o.sclk_o == q.ctl[spc_pkg::B_POL])
    else $error("serial clock not at idle level");
  AST_OVF_CLR: assert property (rd_rx && !done |=> !q.ovf && !q.rxf)
    else $error("receive read did not clear flags");
  AST_SLAVE_CLK: assert property (!mst |-> !pin_o.sclk_oe && !pin_o.mosi_oe)
    else $error("slave drives clock");

  // event, divider and stall timing
  AST_TXE_EVT: assert property (start && mst && q.txv && q.ctl[spc_pkg::B_TMOD]
    |=> q.ist[spc_pkg::I_TXE])
    else $error("transmit empty event missing");
  AST_RXF_EVT: assert property (done && (!q.ctl[spc_pkg::B_TMOD] || !mst)
    |=> q.ist[spc_pkg::I_RXF] && q.rxf)
    else $error("receive full event missing");
  AST_TX_VALID: assert property (bus_i.wr && bus_i.addr == spc_pkg::OFF_TX |=> q.txv)
    else $error("transmit write not held");
  AST_RX_SET: assert property (done |=> q.rxf)
    else $error("completed byte did not mark receive full");
  AST_SCLK_HOLD: assert property (en && mst && q.fsm == spc_pkg::ST_XFER
    && q.hc != 8'h00 && !(bus_i.wr && bus_i.addr == spc_pkg::OFF_CTL)
    |=> $stable(pin_o.sclk_o))
    else $error("serial clock moved inside a half cell");
  AST_HALF_LEN: assert property (en && mst && q.fsm == spc_pkg::ST_XFER
    && q.hc == 8'h00 && !done |=> q.hc == $past(q.div))
    else $error("half cell length not divider plus one");
  AST_STALL_LEN: assert property (done && mst && q.txv && !q.ctl[spc_pkg::B_CONT]
    && q.ctl[spc_pkg::B_TMOD] |=> q.cnt == spc_pkg::STALL_CYC)
    else $error("stall period not loaded");
  AST_STALL_END: assert property (q.fsm == spc_pkg::ST_STALL && q.cnt == 8'h01
    |=> q.fsm == spc_pkg::ST_IDLE)
    else $error("stall period overran");
endmodule : spc_port

// ==== bench/spc_slave_model.sv ====
// behavioural external SPI slave facing the port in master mode
`timescale 1ns/1ps
module spc_slave_model
(
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int n;
  logic [7:0] rs;
  initial
  begin
    miso = 1'b0;
    n = 0;
    rs = 8'h00;
    rx_byte = 8'h00;
  end
  // a frame opens with its first bit already on the line
  always @(negedge ss_n)
  begin
    n = 0;
    miso = tx_byte[lsb ? 0 : 7];
  end
  // a released line shows the inverse of its last level
  always @(posedge ss_n)
    miso = ~miso;
  // sample on one edge, drive on the other; bytes may chain under one select
  always @(sclk)
    if (!ss_n)
    begin
      if ((sclk !== cpol) != cpha)
      begin
        rs[lsb ? n : 7 - n] = mosi;
        n = (n + 1) % 8;
        if (n == 0) rx_byte = rs;
      end
      else
        miso = tx_byte[lsb ? n : 7 - n];
    end
endmodule : spc_slave_model

// ==== bench/spc_port_bench.sv ====
// self-checking bench for the SPI port control block
`timescale 1ns/1ps
module spc_port_bench;
  logic clk, rst_n, irq, b_sclk, b_mosi, b_ss, m_miso;
  logic [15:0] rdata, rv, cfg;
  logic [7:0] m_tx, m_rx, sv;
  int mismatches, cmp_count, n, g, w;
  spc_pkg::spc_bus_t bus;
  spc_pkg::spc_pin_in_t pin_i;
  spc_pkg::spc_pin_out_t pin_o;
  // each wire takes the level of whoever enables it
  assign pin_i.sclk = pin_o.sclk_oe ? pin_o.sclk_o : b_sclk;
  assign pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi_o : b_mosi;
  assign pin_i.ss_n = pin_o.ss_oe ? pin_o.ss_n_o : b_ss;
  assign pin_i.miso = pin_o.miso_oe ? pin_o.miso_o : m_miso;
  spc_port dut (.clk(clk), .rst_n(rst_n), .bus_i(bus), .rdata(rdata), .irq(irq),
    .pin_i(pin_i), .pin_o(pin_o));
  spc_slave_model peer (.sclk(pin_i.sclk), .ss_n(pin_i.ss_n), .mosi(pin_i.mosi),
    .cpol(cfg[3]), .cpha(cfg[2]), .lsb(cfg[5]), .tx_byte(m_tx), .miso(m_miso), .rx_byte(m_rx));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one-cycle register write and read
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd
  // wait for one select frame to open and close
  task automatic frame;
    int t;
    for (t = 0; t < 300 && pin_i.ss_n === 1'b1; t++) @(negedge clk);
    for (t = 0; t < 3000 && pin_i.ss_n !== 1'b1; t++) @(negedge clk);
    w = t; // clocks with select low
    repeat (4) @(posedge clk);
  endtask : frame
  // one frame as external master, mode 0, MSB first, slow clock
  task automatic send(input logic [7:0] d, output logic [7:0] so);
    @(posedge clk);
    b_ss <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      repeat (8) @(posedge clk);
      b_mosi <= d[i];
      repeat (8) @(posedge clk);
      b_sclk <= 1'b1;
      #1 so[i] = pin_o.miso_o;
      if (i == 0) chk("slave oe", 16'(cfg[10]), 16'(pin_o.miso_oe));
      repeat (8) @(posedge clk);
      b_sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    b_ss <= 1'b1;
    repeat (16) @(posedge clk);
  endtask : send
  task automatic t_regs;
    rd(spc_pkg::OFF_CTL);
    chk("ctl reset", 16'h0000, rv);
    rd(spc_pkg::OFF_DIV);
    chk("div reset", 16'h001b, rv);
    wr(spc_pkg::OFF_CTL, 16'hfffe);
    rd(spc_pkg::OFF_CTL);
    chk("ctl rw", 16'h1fee, rv);
    wr(5'h1c, 16'hffff);
    rd(5'h1c);
    chk("unmapped", 16'h0000, rv);
    wr(spc_pkg::OFF_DIV, 16'h0003);
  endtask : t_regs
  // every polarity, phase and bit order, transfers started by a write
  task automatic t_master;
    for (int m = 0; m < 8; m++)
    begin
      cfg = 16'h0243 | {10'h000, m[2], 1'b0, m[1], m[0], 2'b00};
      wr(spc_pkg::OFF_CTL, cfg);
      m_tx = 8'h96 ^ 8'(m);
      repeat (4) @(negedge clk);
      chk("idle sclk", 16'(m[1]), 16'(pin_i.sclk));
      wr(spc_pkg::OFF_TX, 16'h0031 + 16'(m));
      frame;
      chk("frame len", 16'h0040, 16'(w));
      chk("peer rx", 16'h0031 + 16'(m), 16'(m_rx));
      rd(spc_pkg::OFF_RX);
      chk("rx", 16'(m_tx), rv);
    end
  endtask : t_master
  task automatic t_irq;
    wr(spc_pkg::OFF_IST, 16'h000f);
    wr(spc_pkg::OFF_IMSK, 16'h0001);
    wr(spc_pkg::OFF_TX, 16'h00c3);
    frame;
    rd(spc_pkg::OFF_IST);
    chk("int status", 16'h0001, rv);
    chk("irq raised", 16'h0001, 16'(irq));
    wr(spc_pkg::OFF_IMSK, 16'h0000);
    #1 chk("irq masked", 16'h0000, 16'(irq));
    wr(spc_pkg::OFF_IST, 16'h0001);
    wr(spc_pkg::OFF_IMSK, 16'h0001);
    #1 chk("irq cleared", 16'h0000, 16'(irq));
  endtask : t_irq
  // two bytes queued: one frame when chained, two with a stall otherwise
  task automatic t_cont(input logic c);
    logic p;
    cfg = 16'h0243 | {3'b000, c, 12'h000};
    wr(spc_pkg::OFF_CTL, cfg);
    wr(spc_pkg::OFF_TX, 16'h00a1);
    rd(spc_pkg::OFF_STAT);
    for (n = 0; n < 200 && rv[0] !== 1'b0; n++) rd(spc_pkg::OFF_STAT);
    wr(spc_pkg::OFF_TX, 16'h005e);
    n = 0;
    g = 0;
    p = 1'b0;
    repeat (400)
    begin
      @(negedge clk);
      n += int'(!p && pin_i.ss_n);
      g += int'(n == 1 && pin_i.ss_n);
      p = pin_i.ss_n;
    end
    chk("frames", c ? 16'h0001 : 16'h0002, 16'(n));
    if (!c) chk("stall", 16'h0001, 16'(g >= 16));
    chk("last byte", 16'h005e, 16'(m_rx));
  endtask : t_cont
  // read-started transfers, second one with nothing to send
  task automatic t_under(input logic u);
    cfg = 16'h0203 | {8'h00, u, 7'h00};
    wr(spc_pkg::OFF_CTL, cfg);
    wr(spc_pkg::OFF_IST, 16'h000f);
    wr(spc_pkg::OFF_TX, 16'h00a7);
    rd(spc_pkg::OFF_RX);
    frame;
    rd(spc_pkg::OFF_RX);
    frame;
    chk("resent", u ? 16'h00a7 : 16'h0000, 16'(m_rx));
    rd(spc_pkg::OFF_IST);
    chk("int status", 16'h000a, rv);
  endtask : t_under
  task automatic t_loop;
    cfg = 16'h0a43;
    wr(spc_pkg::OFF_CTL, cfg);
    rd(spc_pkg::OFF_RX);
    m_tx = 8'h4b;
    wr(spc_pkg::OFF_TX, 16'h00b4);
    frame;
    rd(spc_pkg::OFF_RX);
    chk("loop rx", 16'h00b4, rv);
  endtask : t_loop
  // two bytes as slave, the second into a full receive register
  task automatic t_slave(input logic v);
    cfg = 16'h0001 | {5'h00, v, 1'b0, v, 8'h00};
    wr(spc_pkg::OFF_CTL, cfg);
    rd(spc_pkg::OFF_RX);
    chk("slave sclk oe", 16'h0000, 16'(pin_o.sclk_oe));
    wr(spc_pkg::OFF_TX, 16'h005a);
    send(8'h81, sv);
    chk("slave out", 16'h005a, 16'(sv));
    wr(spc_pkg::OFF_TX, 16'h00c3);
    send(8'h42, sv);
    chk("slave out", 16'h00c3, 16'(sv));
    rd(spc_pkg::OFF_STAT);
    chk("overflow set", 16'h0038, rv & 16'h0038);
    rd(spc_pkg::OFF_RX);
    chk("kept byte", v ? 16'h0042 : 16'h0081, rv);
    rd(spc_pkg::OFF_STAT);
    chk("overflow clear", 16'h0000, rv & 16'h0038);
  endtask : t_slave
  task automatic t_off;
    cfg = 16'h0242;
    wr(spc_pkg::OFF_CTL, cfg);
    wr(spc_pkg::OFF_TX, 16'h0077);
    n = 0;
    repeat (200)
    begin
      @(negedge clk);
      n += int'(pin_o.ss_n_o !== 1'b1 || pin_o.ss_oe !== 1'b0 || pin_o.sclk_oe !== 1'b0);
    end
    chk("idle while off", 16'h0000, 16'(n));
  endtask : t_off
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog far beyond the expected run
  initial
  begin
    #500000;
    mismatches++;
    test_done;
  end
  initial
  begin
    bus = '0;
    b_sclk = 1'b0;
    b_mosi = 1'b0;
    b_ss = 1'b1;
    cfg = 16'h0000;
    m_tx = 8'h00;
    rst_n = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_master;
    t_irq;
    t_cont(1'b0);
    t_cont(1'b1);
    t_under(1'b0);
    t_under(1'b1);
    t_loop;
    t_slave(1'b0);
    t_slave(1'b1);
    t_off;
    test_done;
  end
endmodule : spc_port_bench
